// ==== verilog/asc_pkg.sv ====
// shared constants and types for the serial converter link
package asc_pkg;
    localparam int WORD_BITS = 16;
    localparam int LEAD_ZEROS = 4;
    localparam int RES_BITS = 12;
    localparam int CNT_W = 5;
    localparam int FULL_FALLS = WORD_BITS + 1;
    localparam int MODE_KEEP_EDGES = 2;
    localparam int NORMAL_KEEP_EDGES = 10;
    localparam int TRACK_EDGE = 13;
    localparam logic SHUTDOWN_RESET = 1'b0;
    localparam logic POWERED_RESET = 1'b0;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MIN_IDLE_GAP_NS = 50;
    localparam int MIN_IDLE_GAP_RAW = (MIN_IDLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_IDLE_GAP_CYC = (MIN_IDLE_GAP_RAW < 1) ? 1 : MIN_IDLE_GAP_RAW;
    localparam int SCLK_HALF_DIV = 3;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        ASC_IDLE = 2'b00,
        ASC_RUN = 2'b01,
        ASC_GAP = 2'b11
    } asc_host_state_type;
endpackage

// ==== verilog/asc_link_if.sv ====
// serial link between the converter and its host
`timescale 1ns/1ps
interface asc_link_if;
    logic serial_shift_clock;
    logic frame_select_n;
    logic serial_result_out;
    logic serial_result_oe;

    modport device (
        input serial_shift_clock,
        input frame_select_n,
        output serial_result_out,
        output serial_result_oe
    );

    modport host (
        output serial_shift_clock,
        output frame_select_n,
        input serial_result_out,
        input serial_result_oe
    );
endinterface

// ==== verilog/asc_device.sv ====
// converter end: frame sequencer, power modes and serial result shifter
`timescale 1ns/1ps

// Notes on behaviour
// - frame select fall starts conversion, normal mode
// - rise between edges two and ten: shutdown
// - rise before second edge keeps mode
// - rise after tenth edge: normal, word truncated
// - shutdown persists until frame select falls
// - host holds select past tenth edge
// - sixteen shift cycles carry one whole word
// - output released after sixteenth cycle
// - host raises select before next frame
// - host waits idle gap between frames
// - first conversion after power-up is dummy
// - wake frame ended early returns to shutdown
// - fully powered after sixteen shift cycles
// - host runs dummy conversion after wake; here the host only flags it on rd_dummy
// - reset starts in normal mode but unpowered; dummy conversion first
// - back-to-back frames at full rate
// - no shutdown cycling above low rates
// - four zeros, then the result msb first, no trailing padding
// - bits launched on falling shift edges
// - hold from frame start to edge thirteen
// - release at seventeenth edge or select rise
module asc_device #(
    parameter int RES_BITS = asc_pkg::RES_BITS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sample_load,
    input wire logic [RES_BITS-1:0] sample_value,
    output logic normal_mode,
    output logic powered,
    output logic holding,
    asc_link_if.device link
);

    localparam int WB = asc_pkg::WORD_BITS;
    localparam int CW = asc_pkg::CNT_W;

    // user clock domain state
    typedef struct packed {
        logic [RES_BITS-1:0] hold;
        logic tgl;
        logic [2:0] mode_s;
        logic [2:0] pow_s;
        logic [2:0] hold_s;
        logic normal_mode;
        logic powered;
        logic holding;
    } asc_user_type;

    // link clock domain state, advanced on falling shift edges
    typedef struct packed {
        logic [2:0] tsync;
        logic seen;
        logic [RES_BITS-1:0] smp;
        logic cs_prev;
        logic in_frame;
        logic [CW-1:0] cnt;
        logic shutdown;
        logic was_shutdown;
        logic powered;
        logic holding;
        logic [WB-1:0] shift;
        logic sdo;
        logic oe;
    } asc_link_type;

    asc_user_type u_r;
    asc_user_type u_nxt;
    asc_link_type l_r;
    asc_link_type l_nxt;

    function automatic logic [WB-1:0] frame_word(input logic [RES_BITS-1:0] v);
        logic [WB-1:0] w;
        w = '0;
        w[WB-asc_pkg::LEAD_ZEROS-1 -: RES_BITS] = v;
        return w;
    endfunction

    // a change of a synchronised level counts once stages two and three agree
    function automatic logic settle(input logic [2:0] s, input logic cur);
        return (s[1] == s[2]) ? s[2] : cur;
    endfunction

    // true when the fall about to be taken is the given one of the frame
    function automatic logic reaches(input logic [CW-1:0] cnt, input int mark);
        return (cnt + CW'(1)) == CW'(mark);
    endfunction

    // power mode left behind when select rises after cnt falls of a frame
    function automatic logic cut_mode(input logic [CW-1:0] cnt, input logic was_off);
        logic off;
        if (cnt >= CW'(asc_pkg::NORMAL_KEEP_EDGES)) begin
            off = 1'b0;
        end else if (cnt >= CW'(asc_pkg::MODE_KEEP_EDGES)) begin
            off = 1'b1;
        end else begin
            // too short to be deliberate; a wake frame falls back too
            off = was_off;
        end
        return off;
    endfunction

    always_comb begin
        u_nxt = u_r;
        if (ce) begin
            // the sample must stay put until the link side has taken it
            if (sample_load) begin
                u_nxt.hold = sample_value;
                u_nxt.tgl = ~u_r.tgl;
            end
            u_nxt.mode_s = {u_r.mode_s[1:0], ~l_r.shutdown};
            u_nxt.pow_s = {u_r.pow_s[1:0], l_r.powered};
            u_nxt.hold_s = {u_r.hold_s[1:0], l_r.holding};
            u_nxt.normal_mode = settle(u_r.mode_s, u_r.normal_mode);
            u_nxt.powered = settle(u_r.pow_s, u_r.powered);
            u_nxt.holding = settle(u_r.hold_s, u_r.holding);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            u_r <= '0;
        end else begin
            u_r <= u_nxt;
        end
    end

    always_comb begin
        logic [WB-1:0] word;
        word = '0;
        l_nxt = l_r;
        // the sample word is read only once its toggle has settled, so it stands still
        l_nxt.tsync = {l_r.tsync[1:0], u_r.tgl};
        if (l_r.tsync[1] == l_r.tsync[2] && l_r.tsync[2] != l_r.seen) begin
            l_nxt.seen = l_r.tsync[2];
            l_nxt.smp = u_r.hold;
        end
        // select moves only on shift clock rises, so it is steady at every fall
        l_nxt.cs_prev = link.frame_select_n;
        if (!link.frame_select_n) begin
            if (l_r.cs_prev) begin
                // frame start; a new frame may follow the last edge directly
                l_nxt.in_frame = 1'b1;
                l_nxt.cnt = CW'(1);
                l_nxt.was_shutdown = l_r.shutdown;
                l_nxt.shutdown = 1'b0;
                l_nxt.holding = 1'b1;
                l_nxt.oe = 1'b1;
                // an unpowered converter yields a dummy all-zero word
                word = l_r.powered ? frame_word(l_r.smp) : '0;
                l_nxt.sdo = word[WB-1];
                l_nxt.shift = {word[WB-2:0], 1'b0};
            end else if (l_r.in_frame) begin
                if (l_r.cnt == CW'(WB)) begin
                    // last bit has had its capture edge; release the line
                    l_nxt.in_frame = 1'b0;
                    l_nxt.oe = 1'b0;
                    // a released pin is shown low so no stale bit lingers on it
                    l_nxt.sdo = 1'b0;
                end else begin
                    l_nxt.cnt = l_r.cnt + CW'(1);
                    l_nxt.sdo = l_r.shift[WB-1];
                    l_nxt.shift = {l_r.shift[WB-2:0], 1'b0};
                    if (reaches(l_r.cnt, asc_pkg::TRACK_EDGE)) begin
                        l_nxt.holding = 1'b0;
                    end
                    if (reaches(l_r.cnt, WB)) begin
                        l_nxt.powered = 1'b1;
                    end
                end
            end
        end else if (l_r.in_frame) begin
            // select rose mid-frame: abort and release the line
            l_nxt.in_frame = 1'b0;
            l_nxt.oe = 1'b0;
            l_nxt.holding = 1'b0;
            l_nxt.sdo = 1'b0;
            l_nxt.shutdown = cut_mode(l_r.cnt, l_r.was_shutdown);
            if (l_nxt.shutdown) begin
                l_nxt.powered = 1'b0;
            end
        end
    end

    // no clock enable here: this domain runs only on edges the host gives
    always_ff @(negedge link.serial_shift_clock or negedge rst_n) begin
        if (!rst_n) begin
            l_r <= '0;
            l_r.cs_prev <= 1'b1;
            l_r.shutdown <= asc_pkg::SHUTDOWN_RESET;
            l_r.powered <= asc_pkg::POWERED_RESET;
        end else begin
            l_r <= l_nxt;
        end
    end

    assign link.serial_result_out = l_r.sdo;
    assign link.serial_result_oe = l_r.oe;
    assign normal_mode = u_r.normal_mode;
    assign powered = u_r.powered;
    assign holding = u_r.holding;

endmodule // asc_device

// ==== verilog/asc_host.sv ====
// host end: shift clock divider, frame select sequencing and word capture
`timescale 1ns/1ps
module asc_host #(
    parameter int HALF_DIV = asc_pkg::SCLK_HALF_DIV,
    parameter int GAP_CYC = asc_pkg::MIN_IDLE_GAP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    input wire logic [asc_pkg::CNT_W-1:0] fall_count,
    output logic busy,
    output logic done,
    output logic rd_full,
    output logic rd_dummy,
    output logic [asc_pkg::WORD_BITS-1:0] rd_data,
    asc_link_if.host link
);

    localparam int WB = asc_pkg::WORD_BITS;
    localparam int CW = asc_pkg::CNT_W;

    typedef struct packed {
        asc_pkg::asc_host_state_type state;
        logic [7:0] div;
        logic sclk;
        logic cs_n;
        logic [CW-1:0] falls;
        logic [CW-1:0] plen;
        logic [7:0] gap;
        logic [2:0] s;
        logic sdo_f;
        logic [WB-1:0] shift;
        logic need_dummy;
        logic busy;
        logic done;
        logic rd_full;
        logic rd_dummy;
        logic [WB-1:0] rd_data;
    } asc_host_st_type;

    asc_host_st_type h_r;
    asc_host_st_type h_nxt;

    always_comb begin
        logic tick;
        tick = 1'b0;
        h_nxt = h_r;
        if (ce) begin
            h_nxt.done = 1'b0;
            h_nxt.s = {h_r.s[1:0], link.serial_result_out & link.serial_result_oe};
            if (h_r.s[1] == h_r.s[2]) begin
                h_nxt.sdo_f = h_r.s[2];
            end
            if (start && !h_r.busy) begin
                h_nxt.busy = 1'b1;
                h_nxt.plen = (fall_count == '0) ? CW'(1) : fall_count;
            end
            tick = (h_r.div == 8'(HALF_DIV - 1));
            h_nxt.div = tick ? 8'h00 : h_r.div + 8'h01;
            if (tick) begin
                // shift clock runs free so the converter sees every select rise
                h_nxt.sclk = ~h_r.sclk;
                if (!h_r.sclk) begin
                    unique case (h_r.state)
                        asc_pkg::ASC_IDLE: begin
                            if (h_r.busy) begin
                                h_nxt.cs_n = 1'b0;
                                h_nxt.falls = '0;
                                h_nxt.state = asc_pkg::ASC_RUN;
                            end
                        end
                        asc_pkg::ASC_RUN: begin
                            // select held low for the requested falling edges
                            if (h_r.falls == h_r.plen) begin
                                h_nxt.cs_n = 1'b1;
                                h_nxt.state = asc_pkg::ASC_GAP;
                                h_nxt.gap = 8'(GAP_CYC);
                                h_nxt.done = 1'b1;
                                h_nxt.rd_data = h_r.shift;
                                h_nxt.rd_full = (h_r.falls == CW'(asc_pkg::FULL_FALLS));
                                h_nxt.rd_dummy = h_r.need_dummy;
                                // a short frame parks the converter; above
                                // modest rates staying awake is cheaper
                                if (h_r.falls < CW'(asc_pkg::NORMAL_KEEP_EDGES)) begin
                                    h_nxt.need_dummy = 1'b1;
                                end else if (h_r.falls >= CW'(asc_pkg::FULL_FALLS)) begin
                                    h_nxt.need_dummy = 1'b0;
                                end
                            end
                        end
                        asc_pkg::ASC_GAP: begin
                        end
                        default: begin
                            h_nxt.state = asc_pkg::ASC_IDLE;
                        end
                    endcase
                end else if (h_r.state == asc_pkg::ASC_RUN && h_r.falls != h_r.plen) begin
                    h_nxt.falls = h_r.falls + CW'(1);
                    // each bit is taken on the falling edge after its launch
                    if (h_r.falls != '0) begin
                        h_nxt.shift = {h_r.shift[WB-2:0], h_r.sdo_f};
                    end
                end
            end
            if (h_r.state == asc_pkg::ASC_GAP) begin
                if (h_r.gap == 8'h00) begin
                    h_nxt.state = asc_pkg::ASC_IDLE;
                    h_nxt.busy = 1'b0;
                end else begin
                    h_nxt.gap = h_r.gap - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            h_r <= '0;
            h_r.cs_n <= 1'b1;
            h_r.need_dummy <= 1'b1;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign link.serial_shift_clock = h_r.sclk;
    assign link.frame_select_n = h_r.cs_n;
    assign busy = h_r.busy;
    assign done = h_r.done;
    assign rd_full = h_r.rd_full;
    assign rd_dummy = h_r.rd_dummy;
    assign rd_data = h_r.rd_data;

endmodule // asc_host

// ==== verification/asc_link_chk.sv ====
// link assertions between the host end and the converter end
`timescale 1ns/1ps
module asc_link_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_shift_clock,
    input wire logic frame_select_n,
    input wire logic serial_result_out,
    input wire logic serial_result_oe
);
    logic [4:0] fall_cnt_r;
    logic [4:0] fall_cnt_nxt;
    // falls seen so far in this frame; sampled value lags the edge by one
    always_comb begin
        fall_cnt_nxt = fall_cnt_r;
        if (frame_select_n) begin
            fall_cnt_nxt = 5'h00;
        end else if (fall_cnt_r != 5'h1f) begin
            fall_cnt_nxt = fall_cnt_r + 5'h01;
        end
    end
    always_ff @(negedge serial_shift_clock or negedge rst_n) begin
        if (!rst_n) begin
            fall_cnt_r <= 5'h00;
        end else begin
            fall_cnt_r <= fall_cnt_nxt;
        end
    end
    sequence frame_start_s;
        frame_select_n ##1 !frame_select_n;
    endsequence
    a_frame_open: assert property (@(negedge serial_shift_clock) disable iff (!rst_n)
        frame_start_s |=> serial_result_oe) else $error("data pin not driven at frame start");
    a_oe_in_word: assert property (@(negedge serial_shift_clock) disable iff (!rst_n)
        !frame_select_n && fall_cnt_r inside {[1:16]} |-> serial_result_oe)
        else $error("data pin released inside word");
    a_oe_after_word: assert property (@(negedge serial_shift_clock) disable iff (!rst_n)
        fall_cnt_r >= 5'h11 |-> !serial_result_oe) else $error("data pin driven after word");
    a_oe_on_rise: assert property (@(negedge serial_shift_clock) disable iff (!rst_n)
        frame_select_n |=> !serial_result_oe) else $error("data pin driven after select rise");
    a_lead_zeros: assert property (@(negedge serial_shift_clock) disable iff (!rst_n)
        !frame_select_n && fall_cnt_r inside {[1:4]} |-> !serial_result_out)
        else $error("leading bit not zero");
    a_sclk_half: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(serial_shift_clock) |-> serial_shift_clock [*3] ##1 !serial_shift_clock)
        else $error("shift clock high phase wrong");
    a_sel_on_rise: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(frame_select_n) |-> $rose(serial_shift_clock))
        else $error("select moved off a shift clock rise");
    a_sel_gap: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(frame_select_n) |-> frame_select_n [*6]) else $error("select high gap too short");
endmodule // asc_link_chk

// ==== verification/adc_serial_mode_control_bench.sv ====
// two-end bench: host and converter joined over the serial link
`timescale 1ns/1ps
module adc_serial_mode_control_bench;
    logic clk;
    logic rst_n;
    logic start;
    logic sample_load;
    logic [asc_pkg::CNT_W-1:0] fall_count;
    logic [asc_pkg::RES_BITS-1:0] sample_value;
    logic busy, done, rd_full, rd_dummy, normal_mode, powered, holding;
    logic [asc_pkg::WORD_BITS-1:0] rd_data;
    int miscompares;
    int samples_checked;
    asc_link_if link ();
    asc_host asc_host_i (.clk(clk), .rst_n(rst_n), .ce(1'b1), .start(start),
        .fall_count(fall_count), .busy(busy), .done(done), .rd_full(rd_full),
        .rd_dummy(rd_dummy), .rd_data(rd_data), .link(link));
    asc_device asc_device_i (.clk(clk), .rst_n(rst_n), .ce(1'b1), .sample_load(sample_load),
        .sample_value(sample_value), .normal_mode(normal_mode), .powered(powered),
        .holding(holding), .link(link));
    asc_link_chk asc_link_chk_i (.clk(clk), .rst_n(rst_n),
        .serial_shift_clock(link.serial_shift_clock), .frame_select_n(link.frame_select_n),
        .serial_result_out(link.serial_result_out), .serial_result_oe(link.serial_result_oe));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task load_sample(input logic [11:0] v);
        @(posedge clk);
        sample_load <= 1'b1;
        sample_value <= v;
        @(posedge clk);
        sample_load <= 1'b0;
        // value must stand for several link periods before the next frame uses it
        repeat (30) @(negedge clk);
    endtask
    // one frame of n falls, then wait for the idle gap and the mode crossing
    task run_frame(input int n);
        int w;
        logic hold_seen;
        hold_seen = 1'b0;
        @(posedge clk);
        start <= 1'b1;
        fall_count <= n[4:0];
        @(posedge clk);
        start <= 1'b0;
        w = 0;
        // outputs are looked at half a period after the edge that moves them
        @(negedge clk);
        while (done !== 1'b1 && w < 2000) begin
            hold_seen = hold_seen | holding;
            @(negedge clk);
            w++;
        end
        while (busy !== 1'b0 && w < 2000) begin
            hold_seen = hold_seen | holding;
            @(negedge clk);
            w++;
        end
        repeat (8) begin
            hold_seen = hold_seen | holding;
            @(negedge clk);
        end
        check(w >= 2000, 1'b0);
        check(hold_seen, 1'b1);
        check(link.serial_result_oe, 1'b0);
        check(holding, 1'b0);
    endtask
    // glitch, shutdown, truncation and wake boundaries in one sequence
    task t_mode_table();
        int n [9];
        logic m [9];
        // a zero count is taken by the host as a single fall
        n = '{17, 0, 1, 2, 1, 10, 9, 12, 17};
        m = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 9; i++) begin
            run_frame(n[i]);
            check(normal_mode, m[i]);
            check(rd_full, n[i] == 17);
        end
        check(rd_dummy, 1'b1);
        check(powered, 1'b1);
        $display("test mode_table done");
    endtask
    task t_shutdown_hold();
        run_frame(2);
        repeat (300) @(negedge clk);
        check(normal_mode, 1'b0);
        check(powered, 1'b0);
        run_frame(17);
        check(rd_dummy, 1'b1);
        check(rd_data, 16'h0000);
        check(normal_mode, 1'b1);
        run_frame(17);
        check(rd_dummy, 1'b0);
        check(rd_data, {4'h0, sample_value});
        $display("test shutdown_hold done");
    endtask
    task t_words();
        logic [11:0] v [2];
        v = '{12'h3f1, 12'h0c6};
        for (int i = 0; i < 2; i++) begin
            load_sample(v[i]);
            run_frame(17);
            check(rd_data, {4'h0, v[i]});
            check(rd_full, 1'b1);
            check(powered, 1'b1);
        end
        $display("test words done");
    endtask
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        fall_count = 5'h11;
        sample_load = 1'b0;
        sample_value = 12'ha5c;
        miscompares = 0;
        samples_checked = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        load_sample(12'ha5c);
        check(normal_mode, 1'b1);
        t_mode_table();
        t_shutdown_hold();
        t_words();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end
endmodule // adc_serial_mode_control_bench
